// ===== core/lsfu_pkg.sv
// Shared types and constants of the load/store format unit
package lsfu_pkg;

  // ==========================================================
  // Operand sizes, addressing modes and operation kinds
  typedef enum logic [1:0] {
    SZ_B = 2'h0,
    SZ_W = 2'h1,
    SZ_L = 2'h2
  } lsfu_size_t;

  typedef enum logic [2:0] {
    AM_IND     = 3'h0,
    AM_POSTINC = 3'h1,
    AM_DISP4   = 3'h2,
    AM_GBASE8  = 3'h3,
    AM_INDEX   = 3'h4
  } lsfu_amode_t;

  typedef enum logic [3:0] {
    K_NOP    = 4'h0,
    K_MOVI   = 4'h1,
    K_ADDI   = 4'h2,
    K_CMPEQI = 4'h3,
    K_TSTI   = 4'h4,
    K_ANDI   = 4'h5,
    K_ORI    = 4'h6,
    K_XORI   = 4'h7,
    K_LOAD   = 4'h8,
    K_STORE  = 4'h9,
    K_ANDM   = 4'hA,
    K_BRA    = 4'hB,
    K_BT     = 4'hC,
    K_BF     = 4'hD
  } lsfu_kind_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    lsfu_kind_t kind;
    lsfu_size_t size;
    lsfu_amode_t amode;
    logic [7:0] imm;
    logic [11:0] disp;
    logic [31:0] regn_val;
    logic [31:0] reg0_val;
    logic [31:0] gbase_val;
    logic [31:0] st_val;
  } lsfu_op_t;

  typedef struct packed {
    logic rd_we;
    logic [31:0] rd_data;
    logic regn_we;
    logic [31:0] regn_data;
  } lsfu_res_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic we;
  } lsfu_mreq_t;

  // ==========================================================
  // Constants
  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
  localparam logic [31:0] ONE_UNIT = 32'h0000_0001;
  localparam logic [31:0] LONG_BYTES = 32'h0000_0004;
  localparam logic [3:0] PERIPH_TAG = 4'hF;
  localparam int PERIPH_LSB = 28;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // ==========================================================
  // Helpers
  function automatic int size_bytes(input lsfu_size_t s);
    return (s == SZ_B) ? 1 : ((s == SZ_W) ? 2 : 4);
  endfunction

  function automatic logic [31:0] sext8(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction

  function automatic logic [31:0] zext8(input logic [7:0] v);
    return {24'h00_0000, v};
  endfunction

endpackage

// ===== core/lsfu_agen.sv
// Effective address generation and alignment check
`timescale 1ns/1ps
module lsfu_agen (
  input lsfu_pkg::lsfu_size_t size,
  input lsfu_pkg::lsfu_amode_t amode,
  input wire logic [31:0] regn_val,
  input wire logic [31:0] reg0_val,
  input wire logic [31:0] gbase_val,
  input wire logic [7:0] disp,
  output logic [31:0] ea,
  output logic [31:0] regn_upd,
  output logic regn_we,
  output logic misalign
);

  // Multiply by operand size in bytes
  function automatic logic [31:0] scale(input lsfu_pkg::lsfu_size_t s,
                                        input logic [31:0] v);
    case (s)
      lsfu_pkg::SZ_B: return v;
      lsfu_pkg::SZ_W: return {v[30:0], 1'b0};
      default: return {v[29:0], 2'b00};
    endcase
  endfunction

  // ==========================================================
  // Address select, post-increment and alignment
  always_comb begin
    regn_we = 1'b0;
    unique case (amode)
      lsfu_pkg::AM_IND: ea = regn_val; // RULE_14
      lsfu_pkg::AM_POSTINC: begin
        ea = regn_val; // RULE_14
        regn_we = 1'b1;
      end
      lsfu_pkg::AM_DISP4:
        ea = regn_val + scale(size, {28'h000_0000, disp[3:0]}); // RULE_15
      lsfu_pkg::AM_GBASE8:
        ea = gbase_val + scale(size, {24'h00_0000, disp}); // RULE_16
      lsfu_pkg::AM_INDEX: ea = regn_val + reg0_val; // RULE_17
      default: ea = regn_val;
    endcase
    regn_upd = regn_val + scale(size, lsfu_pkg::ONE_UNIT); // RULE_14
    misalign = ((size == lsfu_pkg::SZ_W) && ea[0]) ||
               ((size == lsfu_pkg::SZ_L) && (ea[1:0] != 2'h0)); // RULE_03
  end

endmodule // lsfu_agen

// ===== core/lsfu_lane.sv
// Byte lane steering between register and 32-bit memory word
`timescale 1ns/1ps
module lsfu_lane (
  input wire logic big,
  input lsfu_pkg::lsfu_size_t size,
  input wire logic [1:0] off,
  input wire logic [31:0] st_data,
  input wire logic [31:0] rd_word,
  output logic [31:0] wdata,
  output logic [3:0] be,
  output logic [31:0] load_val
);

  logic [1:0] w_pos;
  logic [1:0] w_lane;
  logic [1:0] r_pos;
  logic [1:0] r_lane;
  logic [31:0] raw;

  // ==========================================================
  // Store: register byte i goes to lane off+pos
  always_comb begin
    wdata = 32'h0000_0000;
    be = 4'h0;
    w_pos = 2'h0;
    w_lane = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (i < lsfu_pkg::size_bytes(size)) begin
        w_pos = big ? 2'(lsfu_pkg::size_bytes(size) - 1 - i) : 2'(i); // RULE_04 RULE_06
        w_lane = 2'(off + w_pos);
        wdata[w_lane*8 +: 8] = st_data[i*8 +: 8];
        be[w_lane] = 1'b1;
      end
    end
  end

  // Load: gather bytes, then sign-extend to a longword
  always_comb begin
    raw = 32'h0000_0000;
    r_pos = 2'h0;
    r_lane = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (i < lsfu_pkg::size_bytes(size)) begin
        r_pos = big ? 2'(lsfu_pkg::size_bytes(size) - 1 - i) : 2'(i); // RULE_04 RULE_06
        r_lane = 2'(off + r_pos);
        raw[i*8 +: 8] = rd_word[r_lane*8 +: 8];
      end
    end
    unique case (size)
      lsfu_pkg::SZ_B: load_val = {{24{raw[7]}}, raw[7:0]}; // RULE_02
      lsfu_pkg::SZ_W: load_val = {{16{raw[15]}}, raw[15:0]}; // RULE_02
      default: load_val = raw;
    endcase
  end

endmodule // lsfu_lane

// ===== core/lsfu_core.sv
// Load/store format unit: operand formatting, addressing, branching
// Functional notes
// RULE_01: Register operands and results are always full 32-bit longwords.
// RULE_02: Byte and halfword loads are sign-extended to 32 bits.
// RULE_03: Odd halfword or non-multiple-of-four longword address is an address error.
// RULE_04: Big endian: register MSB at lowest operand address.
// RULE_05: Endian mode sampled from strap pin after reset; low big, then fixed.
// RULE_06: Little endian: register LSB at the base address, MSB at top.
// RULE_07: On-chip memory follows mode; peripheral registers are always big endian.
// RULE_08: Instructions are aligned halfwords, byte order set by endian mode.
// RULE_09: Only fixed 16-bit instructions; most complete in one cycle.
// RULE_10: 8-bit immediates sign-extended for move/add/compare, zero-extended for logic.
// RULE_11: Unconditional branch runs its delay slot instruction, then jumps.
// RULE_12: Compare-equal sets the true flag; add leaves it; branches test it.
// RULE_13: And-with-memory is a read-modify-write on the memory operand.
// RULE_14: Register indirect uses register; post-increment adds 1, 2 or 4 after.
// RULE_15: Four-bit displacement is zero-extended, scaled by size, added to register.
// RULE_16: Eight-bit displacement is zero-extended, scaled, added to global base.
// RULE_17: Indexed mode adds general register n and general register zero.
// RULE_18: Misaligned access issues no bus transfer and raises an error pulse.
`timescale 1ns/1ps
module lsfu_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic endian_select_pin,
  input wire logic op_valid,
  output logic op_ready,
  input lsfu_pkg::lsfu_op_t op,
  output logic res_valid,
  output lsfu_pkg::lsfu_res_t res,
  output logic t_flag,
  output logic addr_err,
  output logic endian_le,
  output logic [31:0] pc,
  input wire logic [31:0] fetch_word,
  output logic [15:0] insn,
  output logic mem_req,
  output lsfu_pkg::lsfu_mreq_t mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_MEM = 2'h1,
    S_RMW = 2'h2
  } lsfu_state_t;

  lsfu_state_t state_reg, state_next;
  lsfu_pkg::lsfu_op_t op_l_reg, op_l_next;
  lsfu_pkg::lsfu_res_t res_reg, res_next;
  lsfu_pkg::lsfu_mreq_t mem_reg, mem_next;
  logic [31:0] pc_reg, pc_next;
  logic [31:0] dly_tgt_reg, dly_tgt_next;
  logic dly_pend_reg, dly_pend_next;
  logic t_reg, t_next;
  logic res_valid_reg, res_valid_next;
  logic addr_err_reg, addr_err_next;
  logic mem_req_reg, mem_req_next;
  logic [15:0] insn_reg, insn_next;
  logic ep_sync1_reg, ep_sync2_reg;
  logic endian_le_reg, endian_le_next;
  logic strap_done_reg, strap_done_next;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic accept, done, taken, is_bra, cmp_eq;
  logic [31:0] br_tgt;
  logic [31:0] ag_ea, ag_regn_upd;
  logic ag_regn_we, ag_misalign;
  lsfu_pkg::lsfu_size_t ln_size;
  logic [31:0] ln_addr, ln_st, ln_wdata, ln_load;
  logic [3:0] ln_be;
  logic ln_big;

  // True for kinds that reach the memory bus
  function automatic logic is_mem(input lsfu_pkg::lsfu_kind_t k);
    return (k == lsfu_pkg::K_LOAD) || (k == lsfu_pkg::K_STORE) ||
           (k == lsfu_pkg::K_ANDM);
  endfunction

  // Peripheral register region decode
  function automatic logic periph(input logic [31:0] a);
    return a[31:lsfu_pkg::PERIPH_LSB] == lsfu_pkg::PERIPH_TAG;
  endfunction

  // Halfword pick from a fetched word in the active byte order
  function automatic logic [15:0] get_half(input logic [31:0] w,
                                           input logic hi,
                                           input logic le);
    logic [15:0] h;
    h = hi ? w[31:16] : w[15:0];
    return le ? h : {h[7:0], h[15:8]};
  endfunction

  // ==========================================================
  // Submodules
  lsfu_agen u_agen (
    .size(op.size),
    .amode(op.amode),
    .regn_val(op.regn_val),
    .reg0_val(op.reg0_val),
    .gbase_val(op.gbase_val),
    .disp(op.disp[7:0]),
    .ea(ag_ea),
    .regn_upd(ag_regn_upd),
    .regn_we(ag_regn_we),
    .misalign(ag_misalign)
  );

  lsfu_lane u_lane (
    .big(ln_big),
    .size(ln_size),
    .off(ln_addr[1:0]),
    .st_data(ln_st),
    .rd_word(mem_rdata),
    .wdata(ln_wdata),
    .be(ln_be),
    .load_val(ln_load)
  );

  // Lane inputs: new op in idle, latched op during the access
  always_comb begin
    if (state_reg == S_IDLE) begin
      ln_size = op.size;
      ln_addr = ag_ea;
      ln_st = op.st_val;
    end else begin
      ln_size = op_l_reg.size;
      ln_addr = mem_reg.addr;
      ln_st = ln_load & lsfu_pkg::zext8(op_l_reg.imm); // RULE_13 RULE_10
    end
    ln_big = !endian_le_reg || periph(ln_addr); // RULE_07
  end

  // ==========================================================
  // Endian strap: two-stage synchroniser, then one capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ep_sync1_reg <= 1'b0;
      ep_sync2_reg <= 1'b0;
    end else begin
      ep_sync1_reg <= endian_select_pin;
      ep_sync2_reg <= ep_sync1_reg;
    end
  end

  // Capture once the synchroniser holds the pin level
  always_comb begin
    strap_cnt_next = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    endian_le_next = endian_le_reg;
    if (!strap_done_reg) begin
      if (strap_cnt_reg == lsfu_pkg::STRAP_WAIT) begin
        endian_le_next = ep_sync2_reg; // RULE_05
        strap_done_next = 1'b1;
      end else begin
        strap_cnt_next = strap_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      endian_le_reg <= 1'b0;
    end else begin
      strap_cnt_reg <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
      endian_le_reg <= endian_le_next;
    end
  end

  // ==========================================================
  // Execution control
  assign op_ready = (state_reg == S_IDLE) && strap_done_reg;
  assign accept = op_valid && op_ready;
  assign cmp_eq = op.regn_val == lsfu_pkg::sext8(op.imm); // RULE_10
  assign br_tgt = pc_reg + lsfu_pkg::PC_AHEAD +
                  {{19{op.disp[11]}}, op.disp, 1'b0};

  // Next state of sequencer, results, bus request and flow
  always_comb begin
    state_next = state_reg;
    op_l_next = op_l_reg;
    res_next = res_reg;
    mem_next = mem_reg;
    mem_req_next = mem_req_reg;
    t_next = t_reg;
    pc_next = pc_reg;
    dly_pend_next = dly_pend_reg;
    dly_tgt_next = dly_tgt_reg;
    res_valid_next = 1'b0;
    addr_err_next = 1'b0;
    done = 1'b0;
    taken = 1'b0;
    is_bra = 1'b0;
    unique case (state_reg)
      S_IDLE: begin
        if (accept) begin
          done = 1'b1; // RULE_09
          res_valid_next = 1'b1;
          res_next = '0;
          case (op.kind)
            lsfu_pkg::K_MOVI: begin
              res_next.rd_we = 1'b1;
              res_next.rd_data = lsfu_pkg::sext8(op.imm); // RULE_10 RULE_01
            end
            lsfu_pkg::K_ADDI: begin
              res_next.rd_we = 1'b1;
              res_next.rd_data = op.regn_val + lsfu_pkg::sext8(op.imm); // RULE_12
            end
            lsfu_pkg::K_CMPEQI: t_next = cmp_eq; // RULE_12
            lsfu_pkg::K_TSTI:
              t_next = ~|(op.reg0_val & lsfu_pkg::zext8(op.imm)); // RULE_10
            lsfu_pkg::K_ANDI: begin
              res_next.rd_we = 1'b1;
              res_next.rd_data = op.reg0_val & lsfu_pkg::zext8(op.imm); // RULE_10
            end
            lsfu_pkg::K_ORI: begin
              res_next.rd_we = 1'b1;
              res_next.rd_data = op.reg0_val | lsfu_pkg::zext8(op.imm); // RULE_10
            end
            lsfu_pkg::K_XORI: begin
              res_next.rd_we = 1'b1;
              res_next.rd_data = op.reg0_val ^ lsfu_pkg::zext8(op.imm); // RULE_10
            end
            lsfu_pkg::K_LOAD, lsfu_pkg::K_STORE, lsfu_pkg::K_ANDM: begin
              if (ag_misalign) begin
                addr_err_next = 1'b1; // RULE_18 RULE_03
              end else begin
                done = 1'b0;
                res_valid_next = 1'b0;
                state_next = S_MEM;
                op_l_next = op;
                mem_req_next = 1'b1;
                mem_next.addr = ag_ea;
                mem_next.wdata = ln_wdata;
                mem_next.be = ln_be;
                mem_next.we = op.kind == lsfu_pkg::K_STORE;
                res_next.regn_we = ag_regn_we; // RULE_14
                res_next.regn_data = ag_regn_upd;
              end
            end
            lsfu_pkg::K_BRA: is_bra = 1'b1; // RULE_11
            lsfu_pkg::K_BT: taken = t_reg; // RULE_12
            lsfu_pkg::K_BF: taken = !t_reg; // RULE_12
            default: begin
            end
          endcase
        end
      end
      S_MEM: begin
        if (mem_ack) begin
          if (op_l_reg.kind == lsfu_pkg::K_ANDM) begin
            state_next = S_RMW; // RULE_13
            mem_next.wdata = ln_wdata;
            mem_next.be = ln_be;
            mem_next.we = 1'b1;
          end else begin
            state_next = S_IDLE;
            mem_req_next = 1'b0;
            done = 1'b1;
            res_valid_next = 1'b1;
            if (op_l_reg.kind == lsfu_pkg::K_LOAD) begin
              res_next.rd_we = 1'b1;
              res_next.rd_data = ln_load; // RULE_02 RULE_01
            end
          end
        end
      end
      S_RMW: begin
        if (mem_ack) begin
          state_next = S_IDLE;
          mem_req_next = 1'b0;
          done = 1'b1;
          res_valid_next = 1'b1;
        end
      end
      default: state_next = S_IDLE;
    endcase
    // Program flow, delay slot first
    if (done) begin
      if (dly_pend_reg) begin
        pc_next = dly_tgt_reg; // RULE_11
        dly_pend_next = 1'b0;
      end else if (is_bra) begin
        pc_next = pc_reg + lsfu_pkg::PC_STEP; // RULE_11
        dly_pend_next = 1'b1;
        dly_tgt_next = br_tgt;
      end else if (taken) begin
        pc_next = br_tgt;
      end else begin
        pc_next = pc_reg + lsfu_pkg::PC_STEP; // RULE_09
      end
    end
    insn_next = get_half(fetch_word, pc_reg[1], endian_le_reg); // RULE_08
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      op_l_reg <= '0;
      res_reg <= '0;
      mem_reg <= '0;
      mem_req_reg <= 1'b0;
      t_reg <= 1'b0;
      pc_reg <= lsfu_pkg::RESET_PC;
      dly_pend_reg <= 1'b0;
      dly_tgt_reg <= lsfu_pkg::RESET_PC;
      res_valid_reg <= 1'b0;
      addr_err_reg <= 1'b0;
      insn_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      op_l_reg <= op_l_next;
      res_reg <= res_next;
      mem_reg <= mem_next;
      mem_req_reg <= mem_req_next;
      t_reg <= t_next;
      pc_reg <= pc_next;
      dly_pend_reg <= dly_pend_next;
      dly_tgt_reg <= dly_tgt_next;
      res_valid_reg <= res_valid_next;
      addr_err_reg <= addr_err_next;
      insn_reg <= insn_next;
    end
  end

  // Outputs
  assign res_valid = res_valid_reg;
  assign res = res_reg;
  assign t_flag = t_reg;
  assign addr_err = addr_err_reg;
  assign endian_le = endian_le_reg;
  assign pc = pc_reg;
  assign insn = insn_reg;
  assign mem_req = mem_req_reg;
  assign mem = mem_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ADDR_ERR_NO_BUS: assert property ( // RULE_18
    accept && is_mem(op.kind) && ag_misalign |=> addr_err && !mem_req)
    else $error("misaligned access reached the bus");

  AST_MISALIGN_W: assert property ( // RULE_03
    accept && is_mem(op.kind) && op.amode == lsfu_pkg::AM_IND &&
    op.size == lsfu_pkg::SZ_W && op.regn_val[0] |=> addr_err)
    else $error("odd halfword address not flagged");

  AST_ENDIAN_FIXED: assert property ( // RULE_05
    strap_done_reg && $past(strap_done_reg) |-> $stable(endian_le_reg))
    else $error("endian mode changed while running");

  AST_ADD_KEEPS_T: assert property ( // RULE_12
    accept && op.kind == lsfu_pkg::K_ADDI |=> $stable(t_reg))
    else $error("add changed the true flag");

  AST_CMPEQ_SETS_T: assert property ( // RULE_12
    accept && op.kind == lsfu_pkg::K_CMPEQI |=> t_reg == $past(cmp_eq))
    else $error("compare-equal flag wrong");

  AST_SLOT_THEN_TARGET: assert property ( // RULE_11
    accept && op.kind == lsfu_pkg::K_BRA && !dly_pend_reg |=>
    dly_pend_reg && pc_reg == $past(pc_reg) + lsfu_pkg::PC_STEP)
    else $error("branch skipped its delay slot");

  AST_SLOT_JUMPS: assert property ( // RULE_11
    dly_pend_reg && done |=> !dly_pend_reg && pc_reg == $past(dly_tgt_reg))
    else $error("delay slot not followed by the target");

  AST_POSTINC_L: assert property ( // RULE_14
    op.amode == lsfu_pkg::AM_POSTINC && op.size == lsfu_pkg::SZ_L |->
    ag_regn_we && ag_regn_upd == op.regn_val + lsfu_pkg::LONG_BYTES)
    else $error("longword post-increment not four");

  AST_LOAD_SEXT_B: assert property ( // RULE_02
    res_valid && res.rd_we && $past(state_reg) == S_MEM &&
    op_l_reg.kind == lsfu_pkg::K_LOAD &&
    op_l_reg.size == lsfu_pkg::SZ_B |-> res.rd_data[31:8] == {24{res.rd_data[7]}})
    else $error("byte load not sign-extended");

  AST_BIG_MSB_LOW: assert property ( // RULE_04
    accept && op.kind == lsfu_pkg::K_STORE && op.size == lsfu_pkg::SZ_L &&
    !ag_misalign && ln_big |=> mem.wdata[7:0] == $past(op.st_val[31:24]))
    else $error("big endian MSB not at lowest address");

  AST_LITTLE_LSB_LOW: assert property ( // RULE_06
    accept && op.kind == lsfu_pkg::K_STORE && op.size == lsfu_pkg::SZ_L &&
    !ag_misalign && !ln_big |=> mem.wdata[7:0] == $past(op.st_val[7:0]))
    else $error("little endian LSB not at base address");

  AST_IMM_ZEXT: assert property ( // RULE_10
    accept && op.kind == lsfu_pkg::K_ORI |=>
    res.rd_data[31:8] == $past(op.reg0_val[31:8]))
    else $error("logical immediate not zero-extended");

endmodule // lsfu_core

// ===== tb/lsfu_mem.sv
// Memory and peripheral bus model facing the load/store unit
`timescale 1ns/1ps
module lsfu_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_req,
  input lsfu_pkg::lsfu_mreq_t mem,
  input wire logic [1:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] m [0:63];
  logic [1:0] wait_reg;

  // ==========================================================
  // Bus answer
  // Ack after lat idle cycles; lane k is byte address {addr,k}
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_reg <= 2'h0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // Stale data never holds for two cycles
      wait_reg <= 2'h0;
      if (mem_req && !mem_ack) begin
        wait_reg <= wait_reg + 2'h1;
        if (wait_reg == lat) begin
          wait_reg <= 2'h0;
          mem_ack <= 1'b1;
          mem_rdata <= m[mem.addr[7:2]];
          for (int k = 0; k < 4; k++) begin
            if (mem.we && mem.be[k]) begin
              m[mem.addr[7:2]][8*k +: 8] <= mem.wdata[8*k +: 8];
            end
          end
        end
      end
    end
  end
endmodule // lsfu_mem

// ===== tb/lsfu_core_tb.sv
// Self-checking bench of the load/store format unit
`timescale 1ns/1ps
module lsfu_core_tb;
  logic clk, rst_n, pin, op_valid, op_ready, res_valid, t_flag;
  logic addr_err, endian_le, mem_req, mem_ack, got_err;
  logic [1:0] lat;
  logic [15:0] insn;
  logic [31:0] pc, fetch_word, mem_rdata;
  lsfu_pkg::lsfu_op_t op;
  lsfu_pkg::lsfu_res_t res, got;
  lsfu_pkg::lsfu_mreq_t mem;
  int bad_count = 0;
  int checks = 0;
  int req_cycles = 0;

  lsfu_core dut (.clk(clk), .rst_n(rst_n), .endian_select_pin(pin),
    .op_valid(op_valid), .op_ready(op_ready), .op(op),
    .res_valid(res_valid), .res(res), .t_flag(t_flag),
    .addr_err(addr_err), .endian_le(endian_le), .pc(pc),
    .fetch_word(fetch_word), .insn(insn), .mem_req(mem_req),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  lsfu_mem u_mem (.clk(clk), .rst_n(rst_n), .mem_req(mem_req),
    .mem(mem), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ==========================================================
  // Clock and bus activity count
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (mem_req) req_cycles++;

  // ==========================================================
  // Report, compare and wait helpers
  task automatic results();
    $display("bad_count=%0d checks=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic bound(inout int n);
    n++;
    if (n > 60) begin
      bad_count++;
      results();
    end
  endtask
  function automatic lsfu_pkg::lsfu_op_t mk(input logic [3:0] k,
    input logic [1:0] s, input logic [2:0] a, input logic [7:0] i,
    input logic [11:0] d, input logic [31:0] vn, input logic [31:0] v0);
    mk = '0;
    mk.kind = lsfu_pkg::lsfu_kind_t'(k);
    mk.size = lsfu_pkg::lsfu_size_t'(s);
    mk.amode = lsfu_pkg::lsfu_amode_t'(a);
    mk.imm = i;
    mk.disp = d;
    mk.regn_val = vn;
    mk.reg0_val = v0;
  endfunction
  // One operation: hold until taken, then catch the result pulse
  task automatic run(input lsfu_pkg::lsfu_op_t o);
    int n;
    n = 0;
    @(posedge clk);
    op <= o;
    op_valid <= 1'b1;
    @(negedge clk);
    while (!op_ready) begin
      bound(n);
      @(negedge clk);
    end
    @(posedge clk);
    op_valid <= 1'b0;
    @(negedge clk);
    while (res_valid !== 1'b1) begin
      bound(n);
      @(negedge clk);
    end
    got = res;
    got_err = addr_err;
  endtask
  task automatic do_reset(input logic le);
    int n;
    n = 0;
    rst_n <= 1'b0;
    pin <= le;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    while (!op_ready) begin
      bound(n);
      @(negedge clk);
    end
    @(negedge clk); // Let insn reload in the captured mode
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_imm();
    run(mk(4'h1, 2'h2, 3'h0, 8'h80, 12'h000, 32'h0, 32'h0));
    chk(32'hFFFF_FF80, got.rd_data);
    @(negedge clk);
    chk(32'h0000_B2A1, {16'h0, insn});
    run(mk(4'h6, 2'h2, 3'h0, 8'h80, 12'h000, 32'h0, 32'h1));
    chk(32'h0000_0081, got.rd_data);
    run(mk(4'h3, 2'h2, 3'h0, 8'h85, 12'h000, 32'hFFFF_FF85, 32'h0));
    chk(32'h1, {31'h0, t_flag});
    run(mk(4'h2, 2'h2, 3'h0, 8'hFF, 12'h000, 32'h1, 32'h0));
    chk(32'h0, got.rd_data);
    chk(32'h1, {31'h0, t_flag});
    run(mk(4'h3, 2'h2, 3'h0, 8'h06, 12'h000, 32'h5, 32'h0));
    chk(32'h0, {31'h0, t_flag});
    run(mk(4'h4, 2'h2, 3'h0, 8'h02, 12'h000, 32'h0, 32'h1));
    chk(32'h1, {31'h0, t_flag});
    run(mk(4'h5, 2'h2, 3'h0, 8'hFF, 12'h000, 32'h0, 32'hF0F0));
    chk(32'h0000_00F0, got.rd_data);
  endtask
  task automatic t_load();
    lsfu_pkg::lsfu_op_t o;
    lat <= 2'h2;
    run(mk(4'h8, 2'h2, 3'h0, 8'h00, 12'h000, 32'h40, 32'h0));
    chk(32'hBBAA_9988, got.rd_data);
    run(mk(4'h8, 2'h0, 3'h1, 8'h00, 12'h000, 32'h41, 32'h0));
    chk(32'hFFFF_FFAA, got.rd_data);
    chk(32'h42, got.regn_data);
    run(mk(4'h8, 2'h1, 3'h2, 8'h00, 12'h002, 32'h3E, 32'h0));
    chk(32'hFFFF_9988, got.rd_data);
    o = mk(4'h8, 2'h2, 3'h3, 8'h00, 12'h008, 32'h0, 32'h0);
    o.gbase_val = 32'h20;
    run(o);
    chk(32'hBBAA_9988, got.rd_data);
    run(mk(4'h8, 2'h0, 3'h4, 8'h00, 12'h000, 32'h40, 32'h3));
    chk(32'hFFFF_FF88, got.rd_data);
    run(mk(4'h8, 2'h2, 3'h1, 8'h00, 12'h000, 32'h40, 32'h0));
    chk(32'h44, got.regn_data);
  endtask
  task automatic t_mis();
    int c;
    c = req_cycles;
    run(mk(4'h8, 2'h1, 3'h0, 8'h00, 12'h000, 32'h41, 32'h0));
    chk(32'h1, {31'h0, got_err});
    run(mk(4'h9, 2'h2, 3'h0, 8'h00, 12'h000, 32'h42, 32'h0));
    chk(32'h1, {31'h0, got_err});
    chk(c, req_cycles);
  endtask
  task automatic t_rmw_branch();
    logic [31:0] p;
    run(mk(4'hA, 2'h0, 3'h0, 8'h0F, 12'h000, 32'h48, 32'h0));
    chk(32'hFFFF_FF0F, u_mem.m[18]);
    p = pc;
    run(mk(4'hB, 2'h2, 3'h0, 8'h00, 12'h004, 32'h0, 32'h0));
    chk(p + 32'h2, pc);
    run(mk(4'h0, 2'h2, 3'h0, 8'h00, 12'h000, 32'h0, 32'h0));
    chk(p + 32'hC, pc);
    chk(32'h1, {31'h0, t_flag});
    p = pc;
    run(mk(4'hC, 2'h2, 3'h0, 8'h00, 12'h002, 32'h0, 32'h0));
    chk(p + 32'h8, pc);
    run(mk(4'hD, 2'h2, 3'h0, 8'h00, 12'h002, 32'h0, 32'h0));
    chk(p + 32'hA, pc);
  endtask
  task automatic t_le();
    lsfu_pkg::lsfu_op_t o;
    @(posedge clk);
    do_reset(1'b1);
    chk(32'h1, {31'h0, endian_le});
    chk(32'h0000_C3D4, {16'h0, insn});
    lat <= 2'h0;
    run(mk(4'h8, 2'h2, 3'h0, 8'h00, 12'h000, 32'h40, 32'h0));
    chk(32'h8899_AABB, got.rd_data);
    o = mk(4'h9, 2'h2, 3'h0, 8'h00, 12'h000, 32'h54, 32'h0);
    o.st_val = 32'h1122_3344;
    run(o);
    chk(32'h1122_3344, u_mem.m[21]);
    o.regn_val = 32'hF000_0050;
    run(o);
    chk(32'h4433_2211, u_mem.m[20]);
    @(posedge clk);
    pin <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'h1, {31'h0, endian_le});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    pin = 1'b0;
    op_valid = 1'b0;
    op = '0;
    lat = 2'h0;
    fetch_word = 32'hA1B2_C3D4;
    u_mem.m[16] = 32'h8899_AABB;
    u_mem.m[18] = 32'hFFFF_FFFF;
    do_reset(1'b0);
    chk(32'h0, {31'h0, endian_le});
    chk(32'h0000_D4C3, {16'h0, insn});
    t_imm();
    t_load();
    t_mis();
    t_rmw_branch();
    t_le();
    results();
  end
endmodule // lsfu_core_tb
